// ===== rtl/uht_xfer_ctrl.sv
// Purpose: Host transfer control for two register sets, A and B.
// Assumes: Serial engine signals share CLK_I; Wishbone classic slave.
// Notes:   Launches one transaction at a time; alternates sets once extended mode is on.
// Functional notes
// R01: Preamble bit one sends a preamble before the low-speed packet.
// R02: Software keeps full speed and sets preamble to reach a hub device.
// R03: Direct low speed set by speed and polarity bits; preamble then ignored. Code decodes the speed bit only.
// R04: Toggle bit picks DATA0 or DATA1, only for OUT transactions.
// R05: Frame start wait holds the packet until after the next SOF.
// R06: Without frame start wait, start at once if engine is free.
// R07: Software leaves frame start wait clear at low speed.
// R08: Isochronous bit marks only the armed packet as isochronous.
// R09: Control bit 3 is reserved and has no function.
// R10: Direction bit one sends OUT from buffer, zero receives IN.
// R11: Enable zero makes the set ignored regardless of arm.
// R12: Arm clears to zero when the transfer completes, with done.
// R13: Software sets up the set, then writes control; start when both set.
// R14: Buffer pointer gives buffer location for OUT fetch or IN store.
// R15: Software may load both pointers before arming OUT transfers.
// R16: Double buffering may point sets at DATA0 and DATA1 payloads.
// R17: After completion the next operation comes from the other set.
// R18: Set B stays inactive until the extended mode register is written.
// R19: Arm with enable zero starts nothing and arm stays set.
`timescale 1ns/1ns
`default_nettype none

module uht_xfer_ctrl (
    input  wire logic              CLK_I,
    input  wire logic              RST_N_I,
    input  wire logic              CYC_I,
    input  wire logic              STB_I,
    input  wire logic              WE_I,
    input  wire logic [3:0]        SEL_I,
    input  wire logic [7:0]        ADR_I,
    input  wire logic [31:0]       DAT_I,
    output logic      [31:0]       DAT_O,
    output logic                   ACK_O,
    input  wire logic              ENGINE_BUSY_I,
    input  wire logic              SOF_SENT_I,
    input  wire logic              XFER_DONE_I,
    output logic                   START_O,
    output uht_pkg::uht_cmd_t      CMD_O,
    output logic                   DONE_O
);

    logic [7:0]          ctl_q [2];
    logic [7:0]          ctl_d [2];
    logic [7:0]          ptr_q [2];
    logic [7:0]          ptr_d [2];
    logic [7:0]          ctl1_q, ctl1_d;
    logic [7:0]          ctl2_q, ctl2_d;
    logic                ext_q, ext_d;
    logic                sel_q, sel_d;
    uht_pkg::uht_state_t state_q, state_d;
    logic                ack_q, ack_d;
    logic [31:0]         dat_q, dat_d;
    logic                start_q, start_d;
    logic                done_q, done_d;
    uht_pkg::uht_cmd_t   cmd_q, cmd_d;

    logic                req, wr_en;
    logic [4:0]          idx;
    logic                low_speed, sync_eff;
    logic                rdy_cur, rdy_oth;
    logic [7:0]          cur_ctl;

    // Bus decode; every request is acknowledged so an unmapped access
    // cannot hang the bus, but only mapped writes land.
    assign req   = CYC_I && STB_I;
    assign idx   = ADR_I[6:2];
    assign wr_en = req && WE_I && SEL_I[0] && ack_q && !ADR_I[7];

    // Set readiness; set B counts only once extended mode is on.
    assign low_speed = ctl1_q[uht_pkg::CTL1_SPEED];
    assign cur_ctl   = ctl_q[sel_q];
    assign sync_eff  = cur_ctl[uht_pkg::CTL_SYNC] && !low_speed; // R05
    assign rdy_cur   = cur_ctl[uht_pkg::CTL_EN] && cur_ctl[uht_pkg::CTL_ARM]
                       && (!sel_q || ext_q); // R11 R18 R19
    assign rdy_oth   = ctl_q[~sel_q][uht_pkg::CTL_EN]
                       && ctl_q[~sel_q][uht_pkg::CTL_ARM]
                       && (sel_q || ext_q); // R18

    // Sequencer and register file next state.
    always_comb begin
        state_d = state_q;
        sel_d   = sel_q;
        start_d = 1'b0;
        done_d  = 1'b0;
        cmd_d   = cmd_q;
        ctl_d   = ctl_q;
        ptr_d   = ptr_q;
        ctl1_d  = ctl1_q;
        ctl2_d  = ctl2_q;
        ext_d   = ext_q;
        case (state_q)
            uht_pkg::ST_IDLE: begin
                if (rdy_cur) begin // R13
                    if (sync_eff) begin
                        state_d = uht_pkg::ST_WAIT_SOF; // R05
                    end else if (!ENGINE_BUSY_I) begin
                        start_d = 1'b1; // R06
                    end
                end else if (rdy_oth) begin
                    sel_d = ~sel_q;
                end
            end
            uht_pkg::ST_WAIT_SOF: begin
                if (!rdy_cur) begin
                    state_d = uht_pkg::ST_IDLE;
                end else if (SOF_SENT_I) begin
                    state_d = uht_pkg::ST_POST_SOF; // R05
                end
            end
            uht_pkg::ST_POST_SOF: begin
                if (!rdy_cur) begin
                    state_d = uht_pkg::ST_IDLE;
                end else if (!ENGINE_BUSY_I) begin
                    start_d = 1'b1;
                end
            end
            uht_pkg::ST_RUN: begin
                if (XFER_DONE_I) begin
                    ctl_d[sel_q][uht_pkg::CTL_ARM] = 1'b0; // R12
                    done_d  = 1'b1;
                    state_d = uht_pkg::ST_IDLE;
                    sel_d   = ext_q ? ~sel_q : 1'b0; // R17
                end
            end
            default: begin
                state_d = uht_pkg::ST_IDLE;
            end
        endcase
        // Launch builds the engine command from the current set.
        if (start_d) begin
            state_d          = uht_pkg::ST_RUN;
            cmd_d.preamble   = cur_ctl[uht_pkg::CTL_PRE] && !low_speed; // R01 R03
            cmd_d.dir_out    = cur_ctl[uht_pkg::CTL_DIR]; // R10
            cmd_d.data1      = cur_ctl[uht_pkg::CTL_TOGGLE]
                               && cur_ctl[uht_pkg::CTL_DIR]; // R04
            cmd_d.iso        = cur_ctl[uht_pkg::CTL_ISO]; // R08
            cmd_d.set_b      = sel_q;
            cmd_d.buf_ptr    = ptr_q[sel_q]; // R14
        end
        // A software write is applied last so a fresh arm is never lost.
        // Bit 3 is stored and read back but steers nothing.
        if (wr_en) begin
            case (idx)
                uht_pkg::IDX_CTL_A: ctl_d[0] = DAT_I[7:0]; // R09
                uht_pkg::IDX_PTR_A: ptr_d[0] = DAT_I[7:0];
                uht_pkg::IDX_CTL_B: ctl_d[1] = DAT_I[7:0];
                uht_pkg::IDX_PTR_B: ptr_d[1] = DAT_I[7:0];
                uht_pkg::IDX_CTL1:  ctl1_d   = DAT_I[7:0];
                uht_pkg::IDX_CTL2: begin
                    ctl2_d = DAT_I[7:0];
                    ext_d  = 1'b1; // R18
                end
                default: begin
                end
            endcase
        end
    end

    // Bus answer: one wait state, then a single-cycle acknowledge.
    always_comb begin
        ack_d = req && !ack_q;
        dat_d = dat_q;
        if (req && !ack_q) begin
            dat_d = uht_pkg::DAT_ZERO;
            case (idx)
                uht_pkg::IDX_CTL_A: dat_d[7:0] = ctl_q[0];
                uht_pkg::IDX_PTR_A: dat_d[7:0] = ptr_q[0];
                uht_pkg::IDX_CTL_B: dat_d[7:0] = ctl_q[1];
                uht_pkg::IDX_PTR_B: dat_d[7:0] = ptr_q[1];
                uht_pkg::IDX_CTL1:  dat_d[7:0] = ctl1_q;
                uht_pkg::IDX_CTL2:  dat_d[7:0] = ctl2_q;
                uht_pkg::IDX_STAT: begin
                    dat_d[uht_pkg::STAT_BUSY] = (state_q == uht_pkg::ST_RUN);
                    dat_d[uht_pkg::STAT_WAIT] =
                        (state_q == uht_pkg::ST_WAIT_SOF);
                    dat_d[uht_pkg::STAT_SETB] = sel_q;
                    dat_d[uht_pkg::STAT_EXT]  = ext_q;
                end
                default: dat_d = uht_pkg::DAT_ZERO;
            endcase
            // The upper half of the address space reads as zero.
            if (ADR_I[7]) begin
                dat_d = uht_pkg::DAT_ZERO;
            end
        end
    end

    // State registers.
    always_ff @(posedge CLK_I) begin
        if (!RST_N_I) begin
            state_q <= uht_pkg::ST_IDLE;
            sel_q   <= 1'b0;
            ext_q   <= 1'b0;
            ctl_q   <= '{uht_pkg::REG_RST, uht_pkg::REG_RST};
            ptr_q   <= '{uht_pkg::REG_RST, uht_pkg::REG_RST};
            ctl1_q  <= uht_pkg::REG_RST;
            ctl2_q  <= uht_pkg::REG_RST;
            ack_q   <= 1'b0;
            dat_q   <= uht_pkg::DAT_ZERO;
            start_q <= 1'b0;
            done_q  <= 1'b0;
            cmd_q   <= uht_pkg::CMD_RST;
        end else begin
            state_q <= state_d;
            sel_q   <= sel_d;
            ext_q   <= ext_d;
            ctl_q   <= ctl_d;
            ptr_q   <= ptr_d;
            ctl1_q  <= ctl1_d;
            ctl2_q  <= ctl2_d;
            ack_q   <= ack_d;
            dat_q   <= dat_d;
            start_q <= start_d;
            done_q  <= done_d;
            cmd_q   <= cmd_d;
        end
    end

    assign DAT_O   = dat_q;
    assign ACK_O   = ack_q;
    assign START_O = start_q;
    assign DONE_O  = done_q;
    assign CMD_O   = cmd_q;

    // Helper terms for the checks below.
    logic pre_eff, tog_eff, iso_cur, dir_cur, wr_cur, arm_cur;
    logic [7:0] ptr_cur;
    assign pre_eff = cur_ctl[uht_pkg::CTL_PRE] && !low_speed;
    assign tog_eff = cur_ctl[uht_pkg::CTL_TOGGLE] && cur_ctl[uht_pkg::CTL_DIR];
    assign iso_cur = cur_ctl[uht_pkg::CTL_ISO];
    assign dir_cur = cur_ctl[uht_pkg::CTL_DIR];
    assign arm_cur = cur_ctl[uht_pkg::CTL_ARM];
    assign ptr_cur = ptr_q[sel_q];
    assign wr_cur  = wr_en && (idx == (sel_q ? uht_pkg::IDX_CTL_B
                                            : uht_pkg::IDX_CTL_A));

    default clocking cb @(posedge CLK_I); endclocking
    default disable iff (!RST_N_I);

    property p_preamble;
        start_d |=> (CMD_O.preamble == $past(pre_eff)) && START_O;
    endproperty
    a_preamble: assert property (p_preamble) // R01
        else $error("Preamble flag does not match launch set.");

    property p_toggle;
        start_d |=> CMD_O.data1 == $past(tog_eff);
    endproperty
    a_toggle: assert property (p_toggle) // R04
        else $error("Data toggle wrong for launched packet.");

    property p_sof_hold;
        (state_q == uht_pkg::ST_WAIT_SOF) |=> !START_O;
    endproperty
    a_sof_hold: assert property (p_sof_hold) // R05
        else $error("Packet launched before frame start was sent.");

    property p_immediate;
        (state_q == uht_pkg::ST_IDLE) && rdy_cur && !sync_eff
            && !ENGINE_BUSY_I |=> START_O ##1 !START_O;
    endproperty
    a_immediate: assert property (p_immediate) // R06
        else $error("Ready set did not launch at once.");

    property p_iso_dir;
        start_d |=> (CMD_O.iso == $past(iso_cur))
                    && (CMD_O.dir_out == $past(dir_cur));
    endproperty
    a_iso_dir: assert property (p_iso_dir) // R08 R10
        else $error("Isochronous or direction flag wrong.");

    property p_disabled;
        !cur_ctl[uht_pkg::CTL_EN] && (state_q == uht_pkg::ST_IDLE)
            |=> !START_O;
    endproperty
    a_disabled: assert property (p_disabled) // R11
        else $error("Disabled set launched a transfer.");

    property p_arm_clear;
        (state_q == uht_pkg::ST_RUN) && XFER_DONE_I && !wr_cur
            |=> DONE_O && !ctl_q[$past(sel_q)][uht_pkg::CTL_ARM];
    endproperty
    a_arm_clear: assert property (p_arm_clear) // R12
        else $error("Arm not cleared with done.");

    property p_pointer;
        start_d |=> CMD_O.buf_ptr == $past(ptr_cur);
    endproperty
    a_pointer: assert property (p_pointer) // R14
        else $error("Buffer pointer not passed to engine.");

    property p_alternate;
        (state_q == uht_pkg::ST_RUN) && XFER_DONE_I && ext_q
            |=> sel_q != $past(sel_q);
    endproperty
    a_alternate: assert property (p_alternate) // R17
        else $error("Next operation not taken from other set.");

    property p_b_idle;
        !ext_q |-> !sel_q && !CMD_O.set_b;
    endproperty
    a_b_idle: assert property (p_b_idle) // R18
        else $error("Set B active before extended mode.");

    property p_arm_hold;
        arm_cur && !cur_ctl[uht_pkg::CTL_EN] && !wr_en
            && (state_q == uht_pkg::ST_IDLE)
            |=> !START_O && ctl_q[$past(sel_q)][uht_pkg::CTL_ARM];
    endproperty
    a_arm_hold: assert property (p_arm_hold) // R19
        else $error("Arm lost while enable was zero.");

    c_launch_a: cover property (START_O && !CMD_O.set_b);
    c_launch_b: cover property (START_O && CMD_O.set_b);
    c_sof_wait: cover property ((state_q == uht_pkg::ST_WAIT_SOF)
                                ##1 (state_q == uht_pkg::ST_POST_SOF));
    c_done:     cover property (DONE_O);

endmodule // uht_xfer_ctrl

`default_nettype wire

// ===== rtl/uht_pkg.sv
// Purpose: Shared constants and types for the host transfer control block.
// Assumes: Registers are word-aligned on a 32-bit Wishbone bus by index.
// Notes:   Byte address of a register is four times its index.
package uht_pkg;

    // Register indices; byte address is index times four.
    localparam logic [4:0] IDX_CTL_A = 5'h00;
    localparam logic [4:0] IDX_PTR_A = 5'h01;
    localparam logic [4:0] IDX_CTL1  = 5'h05;
    localparam logic [4:0] IDX_CTL_B = 5'h08;
    localparam logic [4:0] IDX_PTR_B = 5'h09;
    localparam logic [4:0] IDX_CTL2  = 5'h0f;
    localparam logic [4:0] IDX_STAT  = 5'h10;

    // Transfer control register fields.
    localparam int CTL_ARM    = 0;
    localparam int CTL_EN     = 1;
    localparam int CTL_DIR    = 2;
    localparam int CTL_ISO    = 4;
    localparam int CTL_SYNC   = 5;
    localparam int CTL_TOGGLE = 6;
    localparam int CTL_PRE    = 7;

    // Global control fields.
    localparam int CTL1_SPEED = 5;
    localparam int CTL2_POL   = 6;

    // Status register fields.
    localparam int STAT_BUSY = 0;
    localparam int STAT_WAIT = 1;
    localparam int STAT_SETB = 2;
    localparam int STAT_EXT  = 3;

    localparam logic [7:0]  REG_RST  = 8'h00;
    localparam logic [31:0] DAT_ZERO = 32'h0000_0000;

    // Sequencer states.
    typedef enum logic [3:0] {
        ST_IDLE     = 4'b0001,
        ST_WAIT_SOF = 4'b0010,
        ST_POST_SOF = 4'b0100,
        ST_RUN      = 4'b1000
    } uht_state_t;

    // Command handed to the serial engine with each launch.
    typedef struct packed {
        logic       preamble;
        logic       data1;
        logic       iso;
        logic       dir_out;
        logic       set_b;
        logic [7:0] buf_ptr;
    } uht_cmd_t;

    localparam uht_cmd_t CMD_RST = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 8'h00};

endpackage

// ===== dv/uht_engine_model.sv
// Purpose: Serial engine model facing the host transfer control block.
// Assumes: Shares the block clock and runs one transfer at a time.
// Notes:   Slow mode stretches a transfer so queued sets must wait.
`timescale 1ns/1ns
`default_nettype none

module uht_engine_model (
    input  wire logic clk_i,
    input  wire logic rst_n_i,
    input  wire logic start_i,
    input  wire logic slow_i,
    output logic      busy_o,
    output logic      sof_o,
    output logic      done_o
);
    logic [5:0] run_q;
    logic [5:0] frame_q;

    // Busy from launch to completion, and a frame marker every 48 cycles.
    // Completion is raised only after a launch, never on its own.
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            run_q   <= 6'h00;
            frame_q <= 6'h00;
            busy_o  <= 1'b0;
            sof_o   <= 1'b0;
            done_o  <= 1'b0;
        end else begin
            frame_q <= (frame_q == 6'h2f) ? 6'h00 : frame_q + 6'h01;
            sof_o   <= (frame_q == 6'h2f);
            done_o  <= (run_q == 6'h01);
            if (start_i) begin
                busy_o <= 1'b1;
                run_q  <= slow_i ? 6'h14 : 6'h03;
            end else if (run_q != 6'h00) begin
                run_q  <= run_q - 6'h01;
                busy_o <= (run_q != 6'h01);
            end
        end
    end
endmodule // uht_engine_model

`default_nettype wire

// ===== dv/usb_host_transfer_control_bench.sv
// Purpose: Self-checking bench for the host transfer control block.
// Assumes: Registers sit at four times their index on the bus.
// Notes:   Random set configurations run between fixed corner cases.
`timescale 1ns/1ns
`default_nettype none

module usb_host_transfer_control_bench;
    logic        clk = 1'b0, rst_n = 1'b0, slow = 1'b0;
    logic        cyc = 1'b0, stb = 1'b0, we = 1'b0;
    logic [3:0]  sel = 4'hf;
    logic [7:0]  adr = 8'h00;
    logic [31:0] dat_w = 32'h0;
    logic [31:0] dat_r;
    logic        ack, busy, sof, xdone, start, done, sof_seen;
    uht_pkg::uht_cmd_t cmd, cmd_q;
    int          bad_count = 0, n_tests = 0, n_start = 0;

    uht_xfer_ctrl DUT (
        .CLK_I(clk), .RST_N_I(rst_n), .CYC_I(cyc), .STB_I(stb), .WE_I(we),
        .SEL_I(sel), .ADR_I(adr), .DAT_I(dat_w), .DAT_O(dat_r), .ACK_O(ack),
        .ENGINE_BUSY_I(busy), .SOF_SENT_I(sof), .XFER_DONE_I(xdone),
        .START_O(start), .CMD_O(cmd), .DONE_O(done));

    uht_engine_model ENG (
        .clk_i(clk), .rst_n_i(rst_n), .start_i(start), .slow_i(slow),
        .busy_o(busy), .sof_o(sof), .done_o(xdone));

    // Free-running clock at 100 MHz.
    always #5 clk = ~clk;

    // Frame markers and launches are recorded for ordering checks.
    always @(posedge clk) begin
        if (sof === 1'b1) sof_seen <= 1'b1;
        if (start === 1'b1) n_start <= n_start + 1;
    end

    task automatic finish_test;
        if (bad_count == 0 && n_tests > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] s, e);
        n_tests++;
        if (s !== e) begin
            bad_count++;
            $display("wrong value %s expected %h seen %h", nm, e, s);
        end
    endtask

    // One classic cycle, held until ack is sampled, then idle one cycle.
    task automatic wb(input logic w, input logic [7:0] a, d,
                      output logic [7:0] q);
        int k;
        cyc   <= 1'b1;
        stb   <= 1'b1;
        we    <= w;
        adr   <= a;
        dat_w <= {24'h0, d};
        for (k = 0; k < 20; k++) begin
            @(posedge clk);
            if (ack === 1'b1) break;
        end
        if (k == 20) begin
            bad_count++;
            finish_test();
        end
        q = dat_r[7:0];
        cyc <= 1'b0;
        stb <= 1'b0;
        @(posedge clk);
    endtask

    // Waits a bounded time for a launch or a completion pulse.
    task automatic wait_ev(input logic dn, must, output int n);
        for (n = 0; n < 60; n++) begin
            @(posedge clk);
            if ((dn ? done : start) === 1'b1) begin
                cmd_q = cmd;
                return;
            end
        end
        if (must) begin
            bad_count++;
            finish_test();
        end
    endtask

    // Preamble is dropped at low speed; DATA1 only goes with OUT.
    function automatic uht_pkg::uht_cmd_t exp_cmd(input logic [7:0] c,
        input logic ls, b, input logic [7:0] p);
        exp_cmd = '{c[7] & !ls, c[6] & c[2], c[4], c[2], b, p};
    endfunction

    // Main sequence: reset, corner cases, random sets, ordering.
    initial begin
        int n, s0;
        logic [7:0] q, c, p;
        logic ls;
        logic [7:0] adrs [5] = '{8'h00, 8'h04, 8'h20, 8'h24, 8'h80};
        void'($urandom(93378));
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        foreach (adrs[i]) begin
            wb(1'b0, adrs[i], 8'h00, q);
            chk("reset value", q, 0);
        end
        wb(1'b1, 8'h00, 8'h01, q);
        wb(1'b1, 8'h20, 8'h03, q);
        wait_ev(1'b0, 1'b0, n);
        chk("idle start", n, 60);
        wb(1'b0, 8'h00, 8'h00, q);
        chk("arm kept", q, 8'h01);
        p = 8'($urandom);
        wb(1'b1, 8'h24, p, q);
        wb(1'b1, 8'h3c, 8'h00, q);
        wait_ev(1'b0, 1'b1, n);
        chk("cmd b", cmd_q, exp_cmd(8'h03, 1'b0, 1'b1, p));
        wait_ev(1'b1, 1'b1, n);
        wb(1'b0, 8'h20, 8'h00, q);
        chk("arm clear b", q, 8'h02);
        for (int i = 0; i < 8; i++) begin
            ls = i[0];
            c = (8'($urandom) & 8'hfc) | 8'h03;
            if (ls) c[5] = 1'b0;
            p = 8'($urandom);
            wb(1'b1, 8'h14, {2'b00, ls, 5'h00}, q);
            wb(1'b1, 8'h3c, {1'b0, ls, 6'h00}, q);
            wb(1'b1, 8'h04, p, q);
            wb(1'b1, 8'h00, c, q);
            sof_seen = 1'b0;
            wait_ev(1'b0, 1'b1, n);
            chk("cmd a", cmd_q, exp_cmd(c, ls, 1'b0, p));
            if (c[5]) chk("sof first", sof_seen, 1);
            else chk("prompt", n <= 2, 1);
            wait_ev(1'b1, 1'b1, n);
            wb(1'b0, 8'h00, 8'h00, q);
            chk("arm clear a", q, c & 8'hfe);
        end
        slow <= 1'b1;
        wb(1'b1, 8'h20, 8'h07, q);
        wait_ev(1'b0, 1'b1, n);
        wb(1'b1, 8'h00, 8'h47, q);
        s0 = n_start;
        wait_ev(1'b1, 1'b1, n);
        chk("held while busy", n_start, s0);
        wait_ev(1'b0, 1'b1, n);
        chk("other set next", cmd_q.set_b, 0);
        chk("toggle next", cmd_q.data1, 1);
        wb(1'b0, 8'h40, 8'h00, q);
        chk("status", q, 8'h09);
        sel <= 4'he;
        wb(1'b1, 8'h04, ~p, q);
        sel <= 4'hf;
        wb(1'b0, 8'h04, 8'h00, q);
        chk("lane off write", q, p);
        finish_test();
    end
endmodule // usb_host_transfer_control_bench

`default_nettype wire
